/* File: logic/sfr_pkg.sv */
`default_nettype none
package sfr_pkg;
   // bus geometry: one 32-bit word per register, index = byte address / 4
   localparam int ADDR_W = 12;
   localparam int IDX_LSB = 2;
   localparam int IDX_W = 9;
   localparam int REG_W = 8;
   localparam int PC_W = 13;
   localparam int LATCH_W = 5;

   // register indices inside a bank
   localparam logic [6:0] OFF_INDIRECT = 7'h00;
   localparam logic [6:0] OFF_TIMER0 = 7'h01;
   localparam logic [6:0] OFF_PC_LOW = 7'h02;
   localparam logic [6:0] OFF_STATUS = 7'h03;
   localparam logic [6:0] OFF_POINTER = 7'h04;
   localparam logic [6:0] OFF_PORT_A = 7'h05;
   localparam logic [6:0] OFF_PORT_B = 7'h06;
   localparam logic [6:0] OFF_PC_LATCH = 7'h0A;
   localparam logic [6:0] OFF_INT_CTRL = 7'h0B;
   localparam logic [6:0] OFF_IRQ_FLAGS1 = 7'h0C;
   localparam logic [6:0] OFF_IRQ_FLAGS2 = 7'h0D;
   localparam logic [6:0] OFF_T1_LOW = 7'h0E;
   localparam logic [6:0] OFF_T1_HIGH = 7'h0F;
   localparam logic [6:0] OFF_T1_CTRL = 7'h10;
   localparam logic [6:0] OFF_T2 = 7'h11;
   localparam logic [6:0] OFF_T2_CTRL = 7'h12;
   localparam logic [6:0] OFF_SER_BUF = 7'h13;
   localparam logic [6:0] OFF_SER_CTRL = 7'h14;
   localparam logic [6:0] OFF_CC_LOW = 7'h15;
   localparam logic [6:0] OFF_CC_HIGH = 7'h16;
   localparam logic [6:0] OFF_CC_CTRL = 7'h17;
   localparam logic [6:0] OFF_ADC_HIGH = 7'h1E;
   localparam logic [6:0] OFF_ADC_CTRL = 7'h1F;
   localparam logic [6:0] OFF_SFR_END = 7'h20;
   localparam logic [1:0] BANK_ZERO = 2'h0;

   // implemented-bit masks and the status write mask
   localparam logic [7:0] MASK_IRQ_FLAGS1 = 8'h4F;
   localparam logic [7:0] MASK_IRQ_FLAGS2 = 8'h88;
   localparam logic [7:0] MASK_T1_CTRL = 8'h3F;
   localparam logic [7:0] MASK_T2_CTRL = 8'h7F;
   localparam logic [7:0] MASK_STATUS_WR = 8'hE7;

   // status bit positions
   localparam int ST_IRP = 7;
   localparam int ST_RP1 = 6;
   localparam int ST_RP0 = 5;
   localparam int ST_TO = 4;
   localparam int ST_PD = 3;

   // power-up values (unknown bits taken as zero)
   localparam logic [7:0] POR_STATUS = 8'h18;
   localparam logic [7:0] ZERO8 = 8'h00;
   localparam logic [PC_W-1:0] PC_ZERO = 13'h0000;
   localparam logic [LATCH_W-1:0] LATCH_ZERO = 5'h00;
   localparam logic [31:0] ZERO32 = 32'h0000_0000;

   // keep-masks for the warm reset: 1 = bit keeps its value
   localparam logic [7:0] KEEP_STATUS = 8'h07;
   localparam logic [7:0] KEEP_PORT_A = 8'hF0;
   localparam logic [7:0] KEEP_PORT_B = 8'hFC;
   localparam logic [7:0] KEEP_INT_CTRL = 8'h01;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [31:0] pwdata;
   } sfr_apb_req_t;

   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } sfr_apb_rsp_t;

   // events from the core and peripherals
   typedef struct packed {
      logic pc_step;
      logic pc_load;
      logic [7:0] pc_load_low;
      logic flags_we;
      logic [2:0] flags;
      logic adc_valid;
      logic [7:0] adc_result;
      logic [7:0] irq_flags1_set;
      logic [7:0] irq_flags2_set;
   } sfr_hw_in_t;

   typedef struct packed {
      logic [PC_W-1:0] program_counter;
      logic [7:0] indirect_pointer;
      logic [7:0] cpu_status_flags;
      logic [7:0] interrupt_control;
   } sfr_core_out_t;

   typedef struct packed {
      logic [PC_W-1:0] pc;
      logic [7:0] timer0;
      logic [7:0] status;
      logic [7:0] pointer;
      logic [7:0] port_a;
      logic [7:0] port_b;
      logic [LATCH_W-1:0] latch;
      logic [7:0] int_ctrl;
      logic [7:0] irq_flags1;
      logic [7:0] irq_flags2;
      logic [7:0] t1_low;
      logic [7:0] t1_high;
      logic [7:0] t1_ctrl;
      logic [7:0] t2;
      logic [7:0] t2_ctrl;
      logic [7:0] ser_buf;
      logic [7:0] ser_ctrl;
      logic [7:0] cc_low;
      logic [7:0] cc_high;
      logic [7:0] cc_ctrl;
      logic [7:0] adc_high;
      logic [7:0] adc_ctrl;
      logic [31:0] prdata;
      logic done;
   } sfr_state_t;
endpackage
`default_nettype wire

/* File: logic/sfr_bank0.sv */
//Contract
//- registers hold value until write, update, reset
//- unimplemented addresses and bits read zero
//- program counter high byte has no mapping
//- five-bit latch loads counter bits 12..8
//- core registers appear in every bank
//- pin and watchdog resets use warm values
//- warm reset keeps unchanged, sets cause bits
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module sfr_bank0 (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire sfr_pkg::sfr_apb_req_t apb_req,
   output var sfr_pkg::sfr_apb_rsp_t apb_rsp,
   input wire sfr_pkg::sfr_hw_in_t hw_in,
   input wire logic external_reset_pin,
   input wire logic watchdog_timeout,
   input wire logic cpu_sleeping,
   output var sfr_pkg::sfr_core_out_t core_out
);
   sfr_pkg::sfr_state_t st;
   sfr_pkg::sfr_state_t next_st;
   logic [sfr_pkg::IDX_W-1:0] bus_idx;
   logic [sfr_pkg::IDX_W-1:0] eff_idx;
   logic access;
   logic warm;

   // reads: core registers in any bank, peripherals only in bank 0
   function automatic logic [7:0] read_reg(input sfr_pkg::sfr_state_t s,
                                           input logic [sfr_pkg::IDX_W-1:0] idx);
      logic [1:0] bank;
      logic [6:0] off;
      logic [7:0] v;
      bank = idx[8:7];
      off = idx[6:0];
      v = sfr_pkg::ZERO8;
      case (off)
         sfr_pkg::OFF_PC_LOW: v = s.pc[7:0];
         sfr_pkg::OFF_STATUS: v = s.status;
         sfr_pkg::OFF_POINTER: v = s.pointer;
         sfr_pkg::OFF_PC_LATCH: v = {3'h0, s.latch};
         sfr_pkg::OFF_INT_CTRL: v = s.int_ctrl;
         default: begin
            if (bank == sfr_pkg::BANK_ZERO) begin
               case (off)
                  sfr_pkg::OFF_TIMER0: v = s.timer0;
                  sfr_pkg::OFF_PORT_A: v = s.port_a;
                  sfr_pkg::OFF_PORT_B: v = s.port_b;
                  sfr_pkg::OFF_IRQ_FLAGS1: v = s.irq_flags1 & sfr_pkg::MASK_IRQ_FLAGS1;
                  sfr_pkg::OFF_IRQ_FLAGS2: v = s.irq_flags2 & sfr_pkg::MASK_IRQ_FLAGS2;
                  sfr_pkg::OFF_T1_LOW: v = s.t1_low;
                  sfr_pkg::OFF_T1_HIGH: v = s.t1_high;
                  sfr_pkg::OFF_T1_CTRL: v = s.t1_ctrl & sfr_pkg::MASK_T1_CTRL;
                  sfr_pkg::OFF_T2: v = s.t2;
                  sfr_pkg::OFF_T2_CTRL: v = s.t2_ctrl & sfr_pkg::MASK_T2_CTRL;
                  sfr_pkg::OFF_SER_BUF: v = s.ser_buf;
                  sfr_pkg::OFF_SER_CTRL: v = s.ser_ctrl;
                  sfr_pkg::OFF_CC_LOW: v = s.cc_low;
                  sfr_pkg::OFF_CC_HIGH: v = s.cc_high;
                  sfr_pkg::OFF_CC_CTRL: v = s.cc_ctrl;
                  sfr_pkg::OFF_ADC_HIGH: v = s.adc_high;
                  sfr_pkg::OFF_ADC_CTRL: v = s.adc_ctrl;
                  default: v = sfr_pkg::ZERO8;
               endcase
            end
         end
      endcase
      return v;
   endfunction

   // writes: the same decode, but the ADC high byte is read-only; nothing else moves on a miss
   function automatic sfr_pkg::sfr_state_t write_reg(input sfr_pkg::sfr_state_t s,
                                                     input logic [sfr_pkg::IDX_W-1:0] idx,
                                                     input logic [7:0] d);
      sfr_pkg::sfr_state_t r;
      logic [1:0] bank;
      logic [6:0] off;
      r = s;
      bank = idx[8:7];
      off = idx[6:0];
      case (off)
         sfr_pkg::OFF_PC_LOW: r.pc = {s.latch, d};
         // time-out and power-down flags are hardware-owned
         sfr_pkg::OFF_STATUS: r.status = (s.status & ~sfr_pkg::MASK_STATUS_WR) | (d & sfr_pkg::MASK_STATUS_WR);
         sfr_pkg::OFF_POINTER: r.pointer = d;
         sfr_pkg::OFF_PC_LATCH: r.latch = d[sfr_pkg::LATCH_W-1:0];
         sfr_pkg::OFF_INT_CTRL: r.int_ctrl = d;
         default: begin
            if (bank == sfr_pkg::BANK_ZERO) begin
               case (off)
                  sfr_pkg::OFF_TIMER0: r.timer0 = d;
                  sfr_pkg::OFF_PORT_A: r.port_a = d;
                  sfr_pkg::OFF_PORT_B: r.port_b = d;
                  sfr_pkg::OFF_IRQ_FLAGS1: r.irq_flags1 = d & sfr_pkg::MASK_IRQ_FLAGS1;
                  sfr_pkg::OFF_IRQ_FLAGS2: r.irq_flags2 = d & sfr_pkg::MASK_IRQ_FLAGS2;
                  sfr_pkg::OFF_T1_LOW: r.t1_low = d;
                  sfr_pkg::OFF_T1_HIGH: r.t1_high = d;
                  sfr_pkg::OFF_T1_CTRL: r.t1_ctrl = d & sfr_pkg::MASK_T1_CTRL;
                  sfr_pkg::OFF_T2: r.t2 = d;
                  sfr_pkg::OFF_T2_CTRL: r.t2_ctrl = d & sfr_pkg::MASK_T2_CTRL;
                  sfr_pkg::OFF_SER_BUF: r.ser_buf = d;
                  sfr_pkg::OFF_SER_CTRL: r.ser_ctrl = d;
                  sfr_pkg::OFF_CC_LOW: r.cc_low = d;
                  sfr_pkg::OFF_CC_HIGH: r.cc_high = d;
                  sfr_pkg::OFF_CC_CTRL: r.cc_ctrl = d;
                  sfr_pkg::OFF_ADC_CTRL: r.adc_ctrl = d;
                  default: r = s;
               endcase
            end
         end
      endcase
      return r;
   endfunction

   // bus word index and indirect target
   assign bus_idx = apb_req.paddr[sfr_pkg::IDX_LSB +: sfr_pkg::IDX_W];
   assign access = apb_req.psel && apb_req.penable;
   assign warm = external_reset_pin || watchdog_timeout;

   // the indirect port points through the pointer with the IRP bank bit
   always_comb begin
      eff_idx = bus_idx;
      if (bus_idx[6:0] == sfr_pkg::OFF_INDIRECT) begin
         eff_idx = {st.status[sfr_pkg::ST_IRP], st.pointer};
      end
   end

   // next-state logic
   always_comb begin
      next_st = st;
      next_st.done = 1'b0;
      if (warm) begin
         // warm reset: table values, keeping the unchanged bits
         next_st.pc = sfr_pkg::PC_ZERO;
         next_st.latch = sfr_pkg::LATCH_ZERO;
         next_st.status = st.status & sfr_pkg::KEEP_STATUS;
         next_st.status[sfr_pkg::ST_TO] = ~watchdog_timeout;
         next_st.status[sfr_pkg::ST_PD] = ~cpu_sleeping;
         next_st.port_a = st.port_a & sfr_pkg::KEEP_PORT_A;
         next_st.port_b = st.port_b & sfr_pkg::KEEP_PORT_B;
         next_st.int_ctrl = st.int_ctrl & sfr_pkg::KEEP_INT_CTRL;
         next_st.irq_flags1 = sfr_pkg::ZERO8;
         next_st.irq_flags2 = sfr_pkg::ZERO8;
         next_st.t2 = sfr_pkg::ZERO8;
         next_st.t2_ctrl = sfr_pkg::ZERO8;
         next_st.ser_ctrl = sfr_pkg::ZERO8;
         next_st.cc_ctrl = sfr_pkg::ZERO8;
         next_st.adc_ctrl = sfr_pkg::ZERO8;
         next_st.prdata = sfr_pkg::ZERO32;
      end else begin
         // one wait state: read data is registered before pready
         if (access && !st.done) begin
            next_st.done = 1'b1;
            next_st.prdata = {24'h000000, read_reg(st, eff_idx)};
         end
         // write lands at the edge where pready is sampled high
         if (access && st.done && apb_req.pwrite) begin
            if (bus_idx[6:0] == sfr_pkg::OFF_INDIRECT && st.pointer[6:0] == sfr_pkg::OFF_INDIRECT) begin
               next_st = next_st; // pointer aimed at itself: no effect
            end else if (eff_idx[6:0] < sfr_pkg::OFF_SFR_END) begin
               next_st = write_reg(next_st, eff_idx, apb_req.pwdata[7:0]);
            end
         end
         // counter: a load copies the latch into the upper bits
         if (hw_in.pc_load) begin
            next_st.pc = {st.latch, hw_in.pc_load_low};
         end else if (hw_in.pc_step) begin
            next_st.pc = st.pc + 13'h0001;
         end
         // alu result flags override a same-cycle bus write
         if (hw_in.flags_we) begin
            next_st.status[2:0] = hw_in.flags;
         end
         if (hw_in.adc_valid) begin
            next_st.adc_high = hw_in.adc_result;
         end
         // hardware set wins over a software clear in the same cycle
         next_st.irq_flags1 = next_st.irq_flags1 | (hw_in.irq_flags1_set & sfr_pkg::MASK_IRQ_FLAGS1);
         next_st.irq_flags2 = next_st.irq_flags2 | (hw_in.irq_flags2_set & sfr_pkg::MASK_IRQ_FLAGS2);
      end
   end

   // state register; power-up values on nrst
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         st <= '0;
         st.status <= sfr_pkg::POR_STATUS;
      end else begin
         st <= next_st;
      end
   end

   // the counter high bits only leave on the core port, never on the bus
   // one driver per output struct: field-wise assigns would double-drive a variable
   assign core_out = '{program_counter: st.pc, indirect_pointer: st.pointer,
                       cpu_status_flags: st.status, interrupt_control: st.int_ctrl};
   // misses answer zero, not an error
   assign apb_rsp = '{pready: st.done, pslverr: 1'b0, prdata: st.prdata};
endmodule
`default_nettype wire

/* File: test/sfr_bank0_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module sfr_bank0_chk (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire sfr_pkg::sfr_apb_req_t apb_req,
   input wire sfr_pkg::sfr_apb_rsp_t apb_rsp,
   input wire sfr_pkg::sfr_hw_in_t hw_in,
   input wire logic external_reset_pin,
   input wire logic watchdog_timeout,
   input wire logic cpu_sleeping,
   input wire sfr_pkg::sfr_core_out_t core_out
);
   logic wm;
   logic wr;
   logic rd;
   // warm reset and completed accesses
   assign wm = external_reset_pin | watchdog_timeout;
   assign wr = apb_req.psel & apb_req.penable & apb_rsp.pready & apb_req.pwrite;
   assign rd = apb_req.psel & apb_req.penable & apb_rsp.pready & ~apb_req.pwrite;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   a_one_wait: assert property (
      apb_req.psel && !apb_req.penable |=> !apb_rsp.pready ##1 apb_rsp.pready) else $error("ready not after one wait");
   a_ready_pulse: assert property (apb_rsp.pready |=> !apb_rsp.pready) else $error("ready longer than a cycle");
   a_upper_zero: assert property (
      apb_rsp.pready |-> apb_rsp.prdata[31:8] == 24'h000000) else $error("upper read bits not zero");
   a_unmapped_zero: assert property (
      rd && apb_req.paddr[8:2] >= 7'h20 |-> apb_rsp.prdata == 32'h00000000) else $error("unmapped read not zero");
   a_pc_load: assert property (
      hw_in.pc_load && !wm && !wr |=> core_out.program_counter[7:0] == $past(hw_in.pc_load_low))
      else $error("counter load low byte wrong");
   a_pc_step: assert property (
      hw_in.pc_step && !hw_in.pc_load && !wm && !wr |=>
      core_out.program_counter == $past(core_out.program_counter) + 13'h0001) else $error("counter step wrong");
   a_warm_status: assert property (
      wm |=> core_out.cpu_status_flags == {3'h0, ~$past(watchdog_timeout), ~$past(cpu_sleeping),
      $past(core_out.cpu_status_flags[2:0])}) else $error("warm status wrong");
   a_warm_clear: assert property (
      wm |=> core_out.program_counter == 13'h0000 && core_out.interrupt_control[7:1] == 7'h00 &&
      core_out.interrupt_control[0] == $past(core_out.interrupt_control[0])) else $error("warm clear wrong");
   a_no_error: assert property (
      apb_rsp.pready |-> !apb_rsp.pslverr) else $error("error response raised");
   a_alu_flags: assert property (
      hw_in.flags_we && !wm |=> core_out.cpu_status_flags[2:0] == $past(hw_in.flags))
      else $error("alu flags not taken");
   a_hold_pointer: assert property (
      !wr |=> $stable(core_out.indirect_pointer)) else $error("pointer changed without write");
   // main scenarios
   c_write: cover property (wr);
   c_warm: cover property (wm);
   c_unmapped: cover property (rd && apb_req.paddr[8:2] >= 7'h20);
   c_indirect: cover property (wr && apb_req.paddr[8:2] == 7'h00);
   c_flags: cover property (hw_in.flags_we && !wm);
endmodule
bind sfr_bank0 sfr_bank0_chk u_chk (.clk_sys(clk_sys), .nrst(nrst), .apb_req(apb_req), .apb_rsp(apb_rsp),
   .hw_in(hw_in), .external_reset_pin(external_reset_pin), .watchdog_timeout(watchdog_timeout),
   .cpu_sleeping(cpu_sleeping), .core_out(core_out));
`default_nettype wire

/* File: test/sfr_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sfr_core_model (
   input wire logic clk_sys,
   output var sfr_pkg::sfr_apb_req_t apb_req,
   input wire sfr_pkg::sfr_apb_rsp_t apb_rsp
);
   // bus idle until the first transfer
   initial apb_req = '0;
   // one transfer, held until pready is seen at a rising edge
   task automatic xfer(input logic w, input logic [1:0] b, input logic [6:0] o, input logic [7:0] d);
      @(posedge clk_sys);
      apb_req.psel <= 1'b1;
      apb_req.penable <= 1'b0;
      apb_req.pwrite <= w;
      apb_req.paddr <= {1'b0, b, o, 2'b00};
      apb_req.pwdata <= {24'h000000, d};
      @(posedge clk_sys);
      apb_req.penable <= 1'b1;
      do @(posedge clk_sys); while (apb_rsp.pready !== 1'b1);
      // released lines turn to garbage so a late sample cannot match by luck
      apb_req.psel <= 1'b0;
      apb_req.penable <= 1'b0;
      apb_req.paddr <= ~apb_req.paddr;
      apb_req.pwdata <= ~apb_req.pwdata;
   endtask
endmodule
`default_nettype wire

/* File: test/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clk_sys;
   logic nrst;
   logic external_reset_pin;
   logic watchdog_timeout;
   logic cpu_sleeping;
   sfr_pkg::sfr_apb_req_t apb_req;
   sfr_pkg::sfr_apb_rsp_t apb_rsp;
   sfr_pkg::sfr_hw_in_t hw_in;
   sfr_pkg::sfr_core_out_t core_out;
   logic [7:0] exp_q[$];
   logic [7:0] e;
   logic [7:0] d;
   logic [6:0] offs [7] = '{7'h0C, 7'h0D, 7'h10, 7'h12, 7'h05, 7'h01, 7'h1E};
   logic [7:0] msk [7] = '{8'h4F, 8'h88, 8'h3F, 8'h7F, 8'hFF, 8'hFF, 8'h00};
   logic [6:0] unm [7] = '{7'h07, 7'h08, 7'h09, 7'h18, 7'h1D, 7'h20, 7'h7F};
   integer seed, num_errors, n_compared, i;
   sfr_core_model core (.clk_sys(clk_sys), .apb_req(apb_req), .apb_rsp(apb_rsp));
   sfr_bank0 dut (.clk_sys(clk_sys), .nrst(nrst), .apb_req(apb_req), .apb_rsp(apb_rsp), .hw_in(hw_in),
      .external_reset_pin(external_reset_pin), .watchdog_timeout(watchdog_timeout),
      .cpu_sleeping(cpu_sleeping), .core_out(core_out));
   always #4 clk_sys = ~clk_sys;
   task automatic rd(input int b, input logic [6:0] o, input logic [7:0] x);
      exp_q.push_back(x);
      core.xfer(1'b0, b[1:0], o, 8'h00);
   endtask
   task automatic wr(input int b, input logic [6:0] o, input logic [7:0] x);
      core.xfer(1'b1, b[1:0], o, x);
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      n_compared++;
      if (g !== x) begin
         num_errors++;
         $display("[FAIL] %0t got %h expected %h", $time, g, x);
      end
   endtask
   task automatic stop_test();
      $display("errors %0d compared %0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // read answers are matched to the oldest note at the ready edge
   always @(posedge clk_sys) begin
      if (apb_req.psel && apb_req.penable && !apb_req.pwrite && apb_rsp.pready === 1'b1) begin
         e = exp_q.pop_front();
         chk(apb_rsp.prdata, {24'h000000, e});
      end
   end
   // a hang counts as a mismatch
   initial begin
      #50000;
      num_errors++;
      stop_test();
   end
   initial begin
      clk_sys = 0;
      nrst = 0;
      external_reset_pin = 0;
      watchdog_timeout = 0;
      cpu_sleeping = 0;
      hw_in = '0;
      seed = 32'h4271031B;
      num_errors = 0;
      n_compared = 0;
      repeat (16) @(posedge clk_sys);
      nrst <= 1'b1;
      rd(0, 7'h03, 8'h18);
      rd(0, 7'h0A, 8'h00);
      // masked registers with random data, then unmapped places
      for (i = 0; i < 7; i++) begin
         d = 8'($random(seed));
         wr(0, offs[i], d);
         rd(0, offs[i], d & msk[i]);
         wr(0, unm[i], 8'hFF);
         rd(0, unm[i], 8'h00);
      end
      rd(1, 7'h0C, 8'h00);
      wr(2, 7'h04, 8'h3C);
      rd(3, 7'h04, 8'h3C);
      wr(1, 7'h0A, 8'hFF);
      rd(0, 7'h0A, 8'h1F);
      wr(0, 7'h02, 8'h34);
      repeat (2) @(posedge clk_sys);
      chk({19'h0, core_out.program_counter}, 32'h00001F34);
      hw_in.pc_load <= 1'b1;
      hw_in.pc_load_low <= 8'h80;
      @(posedge clk_sys);
      hw_in.pc_load <= 1'b0;
      hw_in.pc_step <= 1'b1;
      @(posedge clk_sys);
      hw_in.pc_step <= 1'b0;
      rd(0, 7'h02, 8'h81);
      chk({19'h0, core_out.program_counter}, 32'h00001F81);
      // hardware updates for one cycle, then the indirect port through the pointer
      hw_in.adc_valid <= 1'b1;
      hw_in.adc_result <= 8'hC3;
      hw_in.irq_flags1_set <= 8'hFF;
      hw_in.flags_we <= 1'b1;
      hw_in.flags <= 3'h5;
      @(posedge clk_sys);
      hw_in <= '0;
      rd(0, 7'h1E, 8'hC3);
      rd(0, 7'h0C, 8'h4F);
      rd(0, 7'h03, 8'h1D);
      wr(0, 7'h04, 8'h0E);
      wr(1, 7'h00, 8'h77);
      rd(0, 7'h0E, 8'h77);
      rd(3, 7'h00, 8'h77);
      wr(0, 7'h04, 8'h3C);
      // watchdog warm reset while sleeping, then pin reset while awake
      wr(0, 7'h03, 8'hFF);
      rd(0, 7'h03, 8'hFF);
      wr(0, 7'h05, 8'hAB);
      wr(0, 7'h0B, 8'hFF);
      wr(0, 7'h01, 8'h5A);
      cpu_sleeping <= 1'b1;
      watchdog_timeout <= 1'b1;
      @(posedge clk_sys);
      watchdog_timeout <= 1'b0;
      rd(0, 7'h03, 8'h07);
      rd(0, 7'h05, 8'hA0);
      rd(0, 7'h0B, 8'h01);
      rd(0, 7'h01, 8'h5A);
      rd(0, 7'h04, 8'h3C);
      rd(0, 7'h0C, 8'h00);
      cpu_sleeping <= 1'b0;
      external_reset_pin <= 1'b1;
      @(posedge clk_sys);
      external_reset_pin <= 1'b0;
      rd(0, 7'h03, 8'h1F);
      // power-up reset in mid-run restores the cold values
      @(posedge clk_sys);
      nrst <= 1'b0;
      @(posedge clk_sys);
      nrst <= 1'b1;
      rd(0, 7'h03, 8'h18);
      rd(0, 7'h01, 8'h00);
      stop_test();
   end
endmodule
`default_nettype wire
